/* ettrg_pkg.sv */
// Constants and types shared by the external trigger unit
package ettrg_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_IN_MODE     = 8'h04;
	localparam logic [7:0]  OFS_OUT_WIDTH0  = 8'h08;
	localparam logic [7:0]  OFS_OUT_WIDTH1  = 8'h0c;
	localparam logic [7:0]  OFS_STATUS      = 8'h10;
	localparam logic [7:0]  OFS_STOP_COUNT  = 8'h14;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          CTRL_IN_EN_LSB  = 0;
	localparam int          CTRL_OUT_EN_LSB = 2;
	localparam int          MODE_CH1_LSB    = 4;
	localparam int          ST_HIT_LSB      = 0;
	localparam int          ST_STOPREQ_BIT  = 2;
	localparam int          ST_STOPPED_BIT  = 3;
	localparam int          ST_PULSE_LSB    = 4;

	// ************************************************************
	// Channel counts, codes and reset values
	// ************************************************************
	localparam int          NUM_IN          = 2;
	localparam int          NUM_OUT         = 2;
	localparam int          MODE_W          = 3;
	localparam int          WIDTH_W         = 16;
	localparam logic [2:0]  MODE_RISE       = 3'h0;
	localparam logic [2:0]  MODE_FALL       = 3'h1;
	localparam logic [2:0]  MODE_BOTH       = 3'h2;
	localparam logic [2:0]  MODE_HIGH       = 3'h3;
	localparam logic [2:0]  MODE_LOW        = 3'h4;
	localparam logic [15:0] WIDTH_RST       = 16'h0001;
	localparam logic [15:0] WIDTH_MIN       = 16'h0001;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          PULSE_UNIT_NS   = 1000;
	localparam int          CYC_PER_US      = PULSE_UNIT_NS / CLK_PERIOD_NS;
	localparam int          US_CNT_W        = 6;
	localparam logic [5:0]  US_LAST         = 6'(CYC_PER_US - 1);

	// ************************************************************
	// Output channel sequence
	// ************************************************************
	typedef enum logic {
		ETTRG_OUT_IDLE,
		ETTRG_OUT_PULSE
	} ettrg_out_state_t;

endpackage : ettrg_pkg

/* ettrg_in_chan.sv */
// One external trigger input channel: synchroniser and detector
`timescale 1ns/100ps
module ettrg_in_chan
	import ettrg_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// Configuration
	input  wire logic             enable,
	input  wire logic [MODE_W-1:0] mode,
	// Pin and result
	input  wire logic             trig_pin,
	output logic                  hit
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic hit;
	} ettrg_in_state_t;

	ettrg_in_state_t st_reg;
	ettrg_in_state_t st_next;
	logic            rise;
	logic            fall;
	logic            cond;

	always_comb
	begin
		st_next       = st_reg;
		st_next.sync1 = trig_pin;
		st_next.sync2 = st_reg.sync1;
		// Edge history tracks even while disabled, so enabling never fakes an edge
		st_next.prev  = st_reg.sync2;
		rise          = st_reg.sync2 & ~st_reg.prev;
		fall          = ~st_reg.sync2 & st_reg.prev;
		case (mode)
			MODE_RISE: cond = rise;                 // RL3
			MODE_FALL: cond = fall;                 // RL3
			MODE_BOTH: cond = rise | fall;          // RL3
			MODE_HIGH: cond = st_reg.sync2;         // RL4
			MODE_LOW:  cond = ~st_reg.sync2;        // RL4
			default:   cond = 1'b0;
		endcase
		st_next.hit   = enable & cond;              // RL2
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign hit = st_reg.hit;

endmodule : ettrg_in_chan

/* ettrg_out_chan.sv */
// One external trigger output channel: pulse timer in microseconds
`timescale 1ns/100ps
module ettrg_out_chan
	import ettrg_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// Configuration and event
	input  wire logic               enable,
	input  wire logic [WIDTH_W-1:0] width_us,
	input  wire logic               fire,
	// Pin and busy flag
	output logic                    pulse,
	output logic                    busy
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		ettrg_out_state_t    state;
		logic [US_CNT_W-1:0] us_cnt;
		logic [WIDTH_W-1:0]  left;
		logic                pulse;
	} ettrg_out_st_t;

	ettrg_out_st_t st_reg;
	ettrg_out_st_t st_next;

	always_comb
	begin
		st_next = st_reg;
		case (st_reg.state)
			ETTRG_OUT_IDLE:
			begin
				st_next.pulse = 1'b0;                   // RL9
				if (enable && fire)                     // RL8
				begin
					st_next.state  = ETTRG_OUT_PULSE;
					st_next.us_cnt = '0;
					st_next.left   = width_us;          // RL10
					st_next.pulse  = 1'b1;              // RL9
				end
			end
			ETTRG_OUT_PULSE:
			begin
				// A new stop while high is absorbed; the pulse is not stretched
				if (!enable)
				begin
					st_next.state = ETTRG_OUT_IDLE;
					st_next.pulse = 1'b0;
				end
				else if (st_reg.us_cnt == US_LAST)
				begin
					st_next.us_cnt = '0;
					st_next.left   = st_reg.left - WIDTH_MIN;
					if (st_reg.left == WIDTH_MIN)       // RL10
					begin
						st_next.state = ETTRG_OUT_IDLE;
						st_next.pulse = 1'b0;
					end
				end
				else
					st_next.us_cnt = st_reg.us_cnt + 6'h01;
			end
			default:
			begin
				st_next.state = ETTRG_OUT_IDLE;
				st_next.pulse = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			st_reg       <= '0;
			st_reg.state <= ETTRG_OUT_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign pulse = st_reg.pulse;
	assign busy  = (st_reg.state == ETTRG_OUT_PULSE);

endmodule : ettrg_out_chan

/* ettrg_top.sv */
// Two-channel external trigger unit: registers, stop request, pulse outputs
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

// Functional notes
// RL1: Exactly two trigger input channels, 0 and 1, each configured apart.
// RL2: Each input has an enable, cleared at reset; disabled inputs are ignored.
// RL3: Edge detection is rising, falling or both; rising is the reset choice.
// RL4: Level detection alternatively catches a high or a low line level.
// RL5: Any enabled input detection requests a program stop; fixed action.
// RL6: Exactly two trigger output channels, 0 and 1, configured apart.
// RL7: Each output has an enable, cleared at reset; only enabled ones drive.
// RL8: An enabled output fires when the target program stops.
// RL9: Output pulses go high, lines idle low; polarity fixed.
// RL10: Pulse width is 1 to 65535 microseconds, 1 after reset.
module ettrg_top
	import ettrg_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Target core
	input  wire logic              target_stopped,
	output logic                   stop_req,
	// Trigger pins
	input  wire logic [NUM_IN-1:0] trig_in,
	output logic      [NUM_OUT-1:0] trig_out,
	output logic      [NUM_OUT-1:0] trig_out_oe_b
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [NUM_IN-1:0]         in_en;
		logic [NUM_OUT-1:0]        out_en;
		logic [MODE_W-1:0]         mode0;
		logic [MODE_W-1:0]         mode1;
		logic [WIDTH_W-1:0]        width0;
		logic [WIDTH_W-1:0]        width1;
		logic [NUM_IN-1:0]         hit_seen;
		logic                      stop_req;
		logic                      stopped_prev;
		logic                      fire;
		logic [WIDTH_W-1:0]        stop_count;
		logic [DATA_W-1:0]         rdata;
	} ettrg_top_state_t;

	ettrg_top_state_t st_reg;
	ettrg_top_state_t st_next;

	logic [NUM_IN-1:0]  hit;
	logic [NUM_OUT-1:0] pulse;
	logic [NUM_OUT-1:0] busy;
	logic [MODE_W-1:0]  mode_vec [NUM_IN];
	logic [WIDTH_W-1:0] width_vec [NUM_OUT];
	logic [WIDTH_W-1:0] wr_width;
	logic               any_hit;
	logic               stop_edge;

	assign mode_vec[0]  = st_reg.mode0;
	assign mode_vec[1]  = st_reg.mode1;
	assign width_vec[0] = st_reg.width0;
	assign width_vec[1] = st_reg.width1;

	// ************************************************************
	// Channels
	// ************************************************************
	// Fixed channel numbering: generate index is the channel number
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++)
		begin : g_in
			ettrg_in_chan u_in (                                // RL1
				.clk_sys  (clk_sys),
				.rst_b    (rst_b),
				.enable   (st_reg.in_en[gi]),
				.mode     (mode_vec[gi]),
				.trig_pin (trig_in[gi]),
				.hit      (hit[gi])
			);
		end
		for (gi = 0; gi < NUM_OUT; gi++)
		begin : g_out
			ettrg_out_chan u_out (                              // RL6
				.clk_sys  (clk_sys),
				.rst_b    (rst_b),
				.enable   (st_reg.out_en[gi]),
				.width_us (width_vec[gi]),
				.fire     (st_reg.fire),
				.pulse    (pulse[gi]),
				.busy     (busy[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		st_next   = st_reg;
		any_hit   = |hit;
		stop_edge = target_stopped & ~st_reg.stopped_prev;
		// Zero is not a legal width; it is held at the one microsecond floor
		wr_width  = (reg_wdata[WIDTH_W-1:0] == 16'h0000) ?
			WIDTH_MIN : reg_wdata[WIDTH_W-1:0];

		// Stop request towards the core, one cycle per detection
		st_next.stop_req     = any_hit;                          // RL5
		st_next.stopped_prev = target_stopped;
		st_next.fire         = stop_edge;                        // RL8
		if (stop_edge && st_reg.stop_count != 16'hffff)
			st_next.stop_count = st_reg.stop_count + 16'h0001;

		// Register writes
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_CTRL:
				begin
					st_next.in_en  = reg_wdata[CTRL_IN_EN_LSB +: NUM_IN];
					st_next.out_en = reg_wdata[CTRL_OUT_EN_LSB +: NUM_OUT];
				end
				OFS_IN_MODE:
				begin
					st_next.mode0 = reg_wdata[MODE_W-1:0];
					st_next.mode1 = reg_wdata[MODE_CH1_LSB +: MODE_W];
				end
				OFS_OUT_WIDTH0: st_next.width0 = wr_width;           // RL10
				OFS_OUT_WIDTH1: st_next.width1 = wr_width;           // RL10
				OFS_STATUS:
					st_next.hit_seen = st_reg.hit_seen &
						~reg_wdata[ST_HIT_LSB +: NUM_IN];
				OFS_STOP_COUNT: st_next.stop_count = '0;
				default: ;
			endcase
		end

		// Sticky detection flags; a new hit beats a same-cycle clear
		st_next.hit_seen = st_next.hit_seen | hit;

		// Register reads; data stand only in the cycle after the strobe
		st_next.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				OFS_CTRL:
				begin
					st_next.rdata[CTRL_IN_EN_LSB +: NUM_IN]   = st_reg.in_en;
					st_next.rdata[CTRL_OUT_EN_LSB +: NUM_OUT] = st_reg.out_en;
				end
				OFS_IN_MODE:
				begin
					st_next.rdata[MODE_W-1:0]               = st_reg.mode0;
					st_next.rdata[MODE_CH1_LSB +: MODE_W]   = st_reg.mode1;
				end
				OFS_OUT_WIDTH0: st_next.rdata[WIDTH_W-1:0] = st_reg.width0;
				OFS_OUT_WIDTH1: st_next.rdata[WIDTH_W-1:0] = st_reg.width1;
				OFS_STATUS:
				begin
					st_next.rdata[ST_HIT_LSB +: NUM_IN]     = st_reg.hit_seen;
					st_next.rdata[ST_STOPREQ_BIT]           = st_reg.stop_req;
					st_next.rdata[ST_STOPPED_BIT]           = target_stopped;
					st_next.rdata[ST_PULSE_LSB +: NUM_OUT]  = busy;
				end
				OFS_STOP_COUNT: st_next.rdata[WIDTH_W-1:0] = st_reg.stop_count;
				default: st_next.rdata = '0;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			st_reg        <= '0;                                 // RL2 RL7
			st_reg.mode0  <= MODE_RISE;                          // RL3
			st_reg.mode1  <= MODE_RISE;                          // RL3
			st_reg.width0 <= WIDTH_RST;                          // RL10
			st_reg.width1 <= WIDTH_RST;                          // RL10
		end
		else
			st_reg <= st_next;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign reg_rdata     = st_reg.rdata;
	assign stop_req      = st_reg.stop_req;
	assign trig_out      = pulse;                               // RL9
	assign trig_out_oe_b = ~st_reg.out_en;                      // RL7

endmodule : ettrg_top

/* ettrg_props.sv */
// Port checker of the external trigger unit
`timescale 1ns/100ps
module ettrg_props
	import ettrg_pkg::*;
(
	// Clock and reset
	input wire logic               clk_sys,
	input wire logic               rst_b,
	// Register port
	input wire logic [ADDR_W-1:0]  reg_addr,
	input wire logic [DATA_W-1:0]  reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [DATA_W-1:0]  reg_rdata,
	// Target and pins
	input wire logic               target_stopped,
	input wire logic               stop_req,
	input wire logic [NUM_IN-1:0]  trig_in,
	input wire logic [NUM_OUT-1:0] trig_out,
	input wire logic [NUM_OUT-1:0] trig_out_oe_b
);
	// ****
	// Shadow of settings, pulse length counter
	// ****
	logic [3:0]  en_reg;
	logic [2:0]  mode_reg;
	logic [15:0] hi_reg;
	logic        ctrl_wr;
	assign ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
	always_ff @(posedge clk_sys)
	begin
		en_reg   <= !rst_b ? 4'h0 : ctrl_wr ? reg_wdata[3:0] : en_reg;
		mode_reg <= !rst_b ? 3'h0
			: (reg_wr && reg_addr == OFS_IN_MODE) ? reg_wdata[2:0] : mode_reg;
		hi_reg   <= (!rst_b || !trig_out[0]) ? 16'h0 : hi_reg + 16'h1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_rst_out;
		!$past(rst_b) |-> trig_out == 2'h0 && trig_out_oe_b == 2'h3 && !stop_req;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not idle");
	property p_drive;
		(trig_out & trig_out_oe_b) == 2'h0;
	endproperty
	a_drive: assert property (p_drive) else $error("undriven pulse");
	property p_oe;
		ctrl_wr ##1 !ctrl_wr |-> ##1 trig_out_oe_b == ~en_reg[3:2];
	endproperty
	a_oe: assert property (p_oe) else $error("enable not on pin");
	property p_fire;
		$rose(target_stopped) && !trig_out_oe_b[0] && !trig_out[0]
			##1 !trig_out_oe_b[0] |=> trig_out[0];
	endproperty
	a_fire: assert property (p_fire) else $error("no pulse on stop");
	property p_cause;
		$rose(trig_out[1]) |-> $past(target_stopped, 2)
			&& !$past(target_stopped, 3);
	endproperty
	a_cause: assert property (p_cause) else $error("pulse without stop");
	property p_width;
		$fell(trig_out[0]) && !trig_out_oe_b[0] && !$past(trig_out_oe_b[0])
			|-> hi_reg != 16'h0 && hi_reg % 16'h32 == 16'h0;
	endproperty
	a_width: assert property (p_width) else $error("bad pulse length");
	property p_quiet;
		(en_reg[1:0] == 2'h0) [*6] |-> !stop_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stop while off");
	property p_level;
		(en_reg[0] && mode_reg == MODE_HIGH && trig_in[0]) [*6] |-> stop_req;
	endproperty
	a_level: assert property (p_level) else $error("level missed");
	property p_rise;
		en_reg[0] && mode_reg == MODE_RISE && $rose(trig_in[0])
			|-> ##[3:6] stop_req;
	endproperty
	a_rise: assert property (p_rise) else $error("edge missed");
	c_pulse: cover property ($fell(trig_out[0]));
	c_stop: cover property ($rose(stop_req));
	c_both: cover property (trig_out == 2'h3);
endmodule : ettrg_props

bind ettrg_top ettrg_props ettrg_props_i (.clk_sys(clk_sys), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .target_stopped(target_stopped),
	.stop_req(stop_req), .trig_in(trig_in), .trig_out(trig_out),
	.trig_out_oe_b(trig_out_oe_b));

/* ettrg_equip.sv */
// Test equipment model: drives trigger lines, times output pulses
`timescale 1ns/100ps
module ettrg_equip
	import ettrg_pkg::*;
(
	// Clock
	input  wire logic               clk_sys,
	// Pins
	input  wire logic [NUM_OUT-1:0] trig_out,
	input  wire logic [NUM_OUT-1:0] trig_out_oe_b,
	output logic      [NUM_IN-1:0]  trig_in,
	// Measured pulse lengths in cycles
	output logic      [23:0]        width0,
	output logic      [23:0]        width1
);
	// Pull-down on the line while the device does not drive it
	wire  [1:0]  line = trig_out & ~trig_out_oe_b;
	logic [23:0] cnt0 = 24'h0;
	logic [23:0] cnt1 = 24'h0;
	initial trig_in = 2'h0;
	initial width0 = 24'h0;
	initial width1 = 24'h0;
	always @(posedge clk_sys)
	begin
		cnt0 <= line[0] ? cnt0 + 24'h1 : 24'h0;
		cnt1 <= line[1] ? cnt1 + 24'h1 : 24'h0;
		if (!line[0] && cnt0 != 24'h0)
			width0 <= cnt0;
		if (!line[1] && cnt1 != 24'h0)
			width1 <= cnt1;
	end
	task automatic set_line(input int ch, input logic v);
		@(posedge clk_sys);
		trig_in[ch] <= v;
	endtask : set_line
endmodule : ettrg_equip

/* test_ext_trigger_io.sv */
// Self-checking bench of the external trigger unit
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module test_ext_trigger_io
	import ettrg_pkg::*;
;
	logic              clk_sys, rst_b, reg_wr, reg_rd, target_stopped;
	logic              stop_req;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [1:0]        trig_in, trig_out, trig_out_oe_b;
	logic [23:0]       width0, width1;
	int                failures = 0;
	int                total_checks = 0;
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	ettrg_top ettrg_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .target_stopped(target_stopped),
		.stop_req(stop_req), .trig_in(trig_in), .trig_out(trig_out),
		.trig_out_oe_b(trig_out_oe_b));
	ettrg_equip ettrg_equip_i (.clk_sys(clk_sys), .trig_out(trig_out),
		.trig_out_oe_b(trig_out_oe_b), .trig_in(trig_in), .width0(width0),
		.width1(width1));
	task automatic print_verdict();
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(reg_rdata, e)
	endtask : reg_check
	// Ten-cycle excursion from the idle level, stop cycles counted
	task automatic count_stops(input int ch, input logic idle, output int n);
		n = 0;
		fork
			begin
				ettrg_equip_i.set_line(ch, !idle);
				repeat (9) @(posedge clk_sys);
				ettrg_equip_i.set_line(ch, idle);
			end
			repeat (30) @(negedge clk_sys) if (stop_req === 1'b1) n++;
		join
	endtask : count_stops
	task automatic t_reset_values();
		reg_check(OFS_CTRL, 32'h0);
		reg_check(OFS_IN_MODE, 32'h0);
		reg_check(OFS_OUT_WIDTH0, 32'h1);
		reg_check(OFS_OUT_WIDTH1, 32'h1);
		reg_check(8'h40, 32'h0);
		`CHK(trig_out_oe_b, 2'h3)
		`CHK(trig_out, 2'h0)
	endtask : t_reset_values
	task automatic t_in_detect();
		int         n;
		logic [2:0] m;
		int         exp_n [6] = '{1, 1, 2, 10, 10, 0};
		for (int ch = 0; ch < NUM_IN; ch++)
			for (int k = 0; k < 6; k++)
			begin
				m = 3'(k);
				ettrg_equip_i.set_line(ch, m == MODE_LOW);
				reg_write(OFS_IN_MODE, {25'h0, m, 1'b0, m});
				reg_write(OFS_CTRL, 32'h1 << ch);
				repeat (8) @(posedge clk_sys);
				count_stops(ch, m == MODE_LOW, n);
				`CHK(n, exp_n[k])
				reg_write(OFS_CTRL, 32'h0);
			end
		count_stops(0, 1'b0, n);
		`CHK(n, 0)
	endtask : t_in_detect
	task automatic t_out_pulse();
		int i;
		reg_write(OFS_OUT_WIDTH0, 32'hffff);
		reg_check(OFS_OUT_WIDTH0, 32'hffff);
		reg_write(OFS_OUT_WIDTH0, 32'h0);
		reg_check(OFS_OUT_WIDTH0, 32'h1);
		reg_write(OFS_OUT_WIDTH1, 32'h2);
		reg_write(OFS_CTRL, 32'hc);
		repeat (2) @(posedge clk_sys);
		`CHK(trig_out_oe_b, 2'h0)
		target_stopped <= 1'b1;
		// Fire is registered first; the pins rise one cycle after it
		@(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(trig_out, 2'h0)
		@(negedge clk_sys);
		`CHK(trig_out, 2'h3)
		for (i = 0; i < 200 && trig_out !== 2'h0; i++)
			@(negedge clk_sys);
		// A stuck pulse counts as a mismatch; the later checks still run
		if (i == 200)
			failures++;
		@(negedge clk_sys);
		`CHK(width0, 24'h32)
		`CHK(width1, 24'h64)
		@(posedge clk_sys);
		target_stopped <= 1'b0;
		reg_write(OFS_CTRL, 32'h0);
		target_stopped <= 1'b1;
		repeat (6) @(negedge clk_sys);
		`CHK(trig_out, 2'h0)
		`CHK(trig_out_oe_b, 2'h3)
	endtask : t_out_pulse
	// Two stop edges so far; both inputs have hit; target still stopped
	task automatic t_status_regs();
		reg_check(OFS_STOP_COUNT, 32'h2);
		reg_write(OFS_STOP_COUNT, 32'h0);
		reg_check(OFS_STOP_COUNT, 32'h0);
		reg_check(OFS_STATUS, 32'hb);
		reg_write(OFS_STATUS, 32'h3);
		reg_check(OFS_STATUS, 32'h8);
	endtask : t_status_regs
	initial
	begin
		rst_b = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		target_stopped = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset_values();
		t_in_detect();
		t_out_pulse();
		t_status_regs();
		print_verdict();
	end
endmodule : test_ext_trigger_io
